// File: pmp_pkg.sv
// Purpose: Shared constants and types for the panel modulation and polarity block
// Assumes: APB slave with 32-bit data, byte addresses below 4 KiB
// Notes: Field positions follow the register layouts used by the block
package pmp_pkg;

  localparam int PMP_ADDR_W = 12;
  localparam int PMP_DATA_W = 32;
  localparam int PMP_PIN_W = 18;

  // Register byte addresses
  localparam logic [11:0] PMP_CFG_OFS = 12'h604;
  localparam logic [11:0] PMP_MODCTL_OFS = 12'h610;
  localparam logic [11:0] PMP_POL_OFS = 12'h614;
  localparam logic [11:0] PMP_STAT_OFS = 12'h6f0;

  // Field positions
  localparam int PMP_CFG_MODOFF_BIT = 22;
  localparam int PMP_POL_MOD_BIT = 28;
  localparam int PMP_POL_LO_FIRST = 2;
  localparam int PMP_POL_LO_LAST = 7;
  localparam int PMP_POL_HI_FIRST = 10;
  localparam int PMP_POL_HI_LAST = 15;
  localparam int PMP_STAT_MOD_BIT = 0;
  localparam int PMP_STAT_PEND_BIT = 1;
  localparam int PMP_STAT_DLY_BIT = 2;
  localparam int PMP_STAT_CNT_LSB = 8;

  // Writable bits of the polarity register: pins 2..7, 10..15 and the modulation pin
  localparam logic [31:0] PMP_POL_WMASK = 32'h1000_fcfc;
  localparam logic [31:0] PMP_REG_RESET = 32'h0000_0000;

  // Modulation change follows the horizontal sync leading edge by this many clocks
  localparam int PMP_MOD_DELAY_CLKS = 4;
  localparam logic [2:0] PMP_DLY_LOAD = 3'(PMP_MOD_DELAY_CLKS - 1);
  localparam logic [2:0] PMP_DLY_LAST = 3'h1;

  // Modulation and dither control word, laid out as the register
  typedef struct packed {
    logic clk_sel;
    logic [6:0] half_period;
    logic [7:0] tune2;
    logic [7:0] tune1;
    logic [7:0] tune0;
  } pmp_modctl_s;

  // Modulation clock source
  typedef enum logic [0:0] {
    PMP_SRC_VSYNC = 1'b0,
    PMP_SRC_HSYNC = 1'b1
  } pmp_src_e;

  // Dither tuning carrier handed to the gray dither engine
  typedef struct packed {
    logic [7:0] tune2;
    logic [7:0] tune1;
    logic [7:0] tune0;
  } pmp_tune_s;

endpackage

// File: pmp_panel_modulation_polarity.sv
// Purpose: Panel modulation clock generator, dither tuning registers and pin polarity stage
// Assumes: Internal sync pulses and panel data come from logic on pclk
// Notes: Pin outputs are registered, so panel data reaches the pins one clock after entry
`timescale 1ns/1ps
`default_nettype none

module pmp_panel_modulation_polarity
  import pmp_pkg::*;
#(
  parameter int PIN_W = PMP_PIN_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMP_ADDR_W-1:0] paddr,
  input wire logic [PMP_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [PMP_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic int_vsync,
  input wire logic int_hsync,
  input wire logic [PIN_W-1:0] panel_data_in,
  output pmp_tune_s frame_rate_gray_dither_tune,
  output logic [PIN_W-1:0] panel_data_pin,
  output logic panel_modulation_clock
);

  typedef enum logic [1:0] {
    PMP_ST_IDLE = 2'b00,
    PMP_ST_WAIT = 2'b01,
    PMP_ST_DELAY = 2'b10
  } pmp_mod_state_e;

  logic [31:0] cfg_r;
  pmp_modctl_s modctl_r;
  logic [31:0] pol_r;
  logic vs_d_r;
  logic hs_d_r;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic pend_r;
  logic [2:0] dly_r;
  pmp_mod_state_e state_r;
  pmp_mod_state_e state_nxt;
  logic mod_r;
  logic mod_nxt;
  logic mod_pin_r;
  logic [PIN_W-1:0] data_pin_r;
  logic [PIN_W-1:0] pol_mask;
  logic vs_rise;
  logic hs_rise;
  logic src_event;
  logic terminal;
  logic arm;
  logic keep_new;
  logic toggle_now;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [31:0] byte_mask;
  logic [31:0] stat_word;

  // APB decode; no wait states, so every access completes in its first access cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign addr_hit = (paddr == PMP_CFG_OFS) || (paddr == PMP_MODCTL_OFS) ||
                    (paddr == PMP_POL_OFS) || (paddr == PMP_STAT_OFS);
  // Unmapped addresses answer with an error; writes to them change nothing
  // pslverr follows the request directly, so it stands only during the access phase
  assign pslverr = psel & penable & ~addr_hit;
  assign byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  // Configuration register: only the modulation disable bit is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_r <= PMP_REG_RESET;
    else if (wr_en && paddr == PMP_CFG_OFS && pstrb[PMP_CFG_MODOFF_BIT/8])
      cfg_r[PMP_CFG_MODOFF_BIT] <= pwdata[PMP_CFG_MODOFF_BIT];
  end

  // Tuning fields, half-period and source select, byte lane writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      modctl_r <= pmp_modctl_s'(PMP_REG_RESET);
    else if (wr_en && paddr == PMP_MODCTL_OFS)
      modctl_r <= pmp_modctl_s'((modctl_r & ~byte_mask) | (pwdata & byte_mask));
  end

  // Polarity register; reserved positions are not stored, so stray ones read back as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pol_r <= PMP_REG_RESET;
    else if (wr_en && paddr == PMP_POL_OFS)
      pol_r <= ((pol_r & ~byte_mask) | (pwdata & byte_mask)) & PMP_POL_WMASK;
  end

  // Status word shows the live modulation state
  always_comb
  begin
    stat_word = 32'h0000_0000;
    stat_word[PMP_STAT_MOD_BIT] = mod_r;
    stat_word[PMP_STAT_PEND_BIT] = pend_r;
    stat_word[PMP_STAT_DLY_BIT] = (state_r == PMP_ST_DELAY);
    stat_word[PMP_STAT_CNT_LSB +: 7] = cnt_r;
  end

  // Read data is registered and valid at the completing edge of the access
  // Loading in the setup cycle keeps prdata a flop output; status shows the setup-cycle state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        PMP_CFG_OFS: prdata <= cfg_r;
        PMP_MODCTL_OFS: prdata <= modctl_r;
        PMP_POL_OFS: prdata <= pol_r;
        PMP_STAT_OFS: prdata <= stat_word;
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign frame_rate_gray_dither_tune = {modctl_r.tune2, modctl_r.tune1, modctl_r.tune0};

  // Sync edge detectors; the sync pulses are from pclk logic and need no synchroniser
  // Reset value matches the idle low level, so no false edge follows reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vs_d_r <= 1'b0;
      hs_d_r <= 1'b0;
    end
    else
    begin
      vs_d_r <= int_vsync;
      hs_d_r <= int_hsync;
    end
  end

  assign vs_rise = int_vsync & ~vs_d_r;
  assign hs_rise = int_hsync & ~hs_d_r;
  assign src_event = (pmp_src_e'(modctl_r.clk_sel) == PMP_SRC_HSYNC) ? hs_rise : vs_rise;
  // With the disable bit set the period is ignored and every source event ends a half-period
  assign terminal = cfg_r[PMP_CFG_MODOFF_BIT] ? 1'b1 : (cnt_r >= modctl_r.half_period);
  assign arm = pend_r | (src_event & terminal);

  // Half-period counter counts source events, programmed value plus one per half-period
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (src_event)
      cnt_nxt = terminal ? 7'h00 : 7'(cnt_r + 7'h01);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= 7'h00;
    else
      cnt_r <= cnt_nxt;
  end

  // An hsync edge that starts a delay serves one request only: the stored one if there is
  // one, else the fresh one. A fresh end therefore stays pending while a delay runs or while
  // an older request is being served; a further end while one is already pending is lost.
  assign keep_new = src_event & terminal & (~hs_rise | pend_r | (state_r == PMP_ST_DELAY));

  // A finished half-period waits for the next hsync leading edge; the set beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pend_r <= 1'b0;
    else if (keep_new)
      pend_r <= 1'b1;
    else if (hs_rise && state_r != PMP_ST_DELAY)
      pend_r <= 1'b0;
  end

  // Toggle sequencer: hsync edge starts a fixed delay before the change
  always_comb
  begin
    state_nxt = state_r;
    toggle_now = 1'b0;
    case (state_r)
      PMP_ST_IDLE:
      begin
        if (hs_rise && arm)
          state_nxt = PMP_ST_DELAY;
        else if (arm)
          state_nxt = PMP_ST_WAIT;
      end
      PMP_ST_WAIT:
      begin
        if (hs_rise)
          state_nxt = PMP_ST_DELAY;
      end
      PMP_ST_DELAY:
      begin
        if (dly_r == PMP_DLY_LAST)
        begin
          toggle_now = 1'b1;
          state_nxt = pend_r ? PMP_ST_WAIT : PMP_ST_IDLE;
        end
      end
      default: state_nxt = PMP_ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= PMP_ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Delay counter loaded on entry to the delay state
  // Entry cycle plus three counted cycles puts the change four clocks after the hsync edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dly_r <= 3'h0;
    else if (state_r != PMP_ST_DELAY && state_nxt == PMP_ST_DELAY)
      dly_r <= PMP_DLY_LOAD;
    else if (state_r == PMP_ST_DELAY)
      dly_r <= 3'(dly_r - 3'h1);
  end

  // True-sense modulation signal
  assign mod_nxt = toggle_now ? ~mod_r : mod_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mod_r <= 1'b0;
    else
      mod_r <= mod_nxt;
  end

  // Per-pin polarity mask; reserved pins never invert
  // Pins 16 and up have no polarity bit here and always pass straight through
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_pol
      if ((gi >= PMP_POL_LO_FIRST) && (gi <= PMP_POL_LO_LAST))
      begin : g_lo
        assign pol_mask[gi] = pol_r[gi];
      end
      else if ((gi >= PMP_POL_HI_FIRST) && (gi <= PMP_POL_HI_LAST))
      begin : g_hi
        assign pol_mask[gi] = pol_r[gi];
      end
      else
      begin : g_none
        assign pol_mask[gi] = 1'b0;
      end
    end
  endgenerate

  // Final inversion stage at the pins; the timing logic above stays true-sense
  // A polarity write moves the pins one clock later, and only ever on a clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_pin_r <= '0;
      mod_pin_r <= 1'b0;
    end
    else
    begin
      data_pin_r <= panel_data_in ^ pol_mask;
      mod_pin_r <= mod_nxt ^ pol_r[PMP_POL_MOD_BIT];
    end
  end

  assign panel_data_pin = data_pin_r;
  assign panel_modulation_clock = mod_pin_r;

endmodule // pmp_panel_modulation_polarity

`default_nettype wire

// File: pmp_props.sv
// Purpose: Port checks for the panel modulation and polarity block
// Assumes: One pclk domain; hsync stays quiet near polarity writes
// Notes: Polarity effects are judged two samples after the write
`timescale 1ns/1ps
`default_nettype none
module pmp_props
  import pmp_pkg::*;
#(
  parameter int PIN_W = PMP_PIN_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PMP_ADDR_W-1:0] paddr,
  input wire logic [PMP_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pslverr,
  input wire logic int_hsync,
  input wire logic [PIN_W-1:0] panel_data_in,
  input wire pmp_tune_s frame_rate_gray_dither_tune,
  input wire logic [PIN_W-1:0] panel_data_pin,
  input wire logic panel_modulation_clock
);
  logic pol_mod_r;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Last written pin polarity, so the expected flip is known
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pol_mod_r <= 1'b0;
    else if (psel && penable && pwrite && paddr == PMP_POL_OFS && pstrb[PMP_POL_MOD_BIT/8])
      pol_mod_r <= pwdata[PMP_POL_MOD_BIT];
  end
  // Steps: completed write, hsync lead four back, polarity write two back
  sequence s_wr(a);
    psel && penable && pwrite && paddr == a;
  endsequence
  sequence s_hs_lead;
    $past(int_hsync, 4) && !$past(int_hsync, 5);
  endsequence
  sequence s_pol_ago;
    $past(psel && penable && pwrite && paddr == PMP_POL_OFS, 2);
  endsequence
  a_tune_load: assert property (s_wr(PMP_MODCTL_OFS) ##0 pstrb == 4'hf
    |=> frame_rate_gray_dither_tune == $past(pwdata[23:0])) else $error("tune differs from write");
  a_tune_hold: assert property (!(psel && penable && pwrite) |=> $stable(frame_rate_gray_dither_tune))
    else $error("tune moved without write");
  a_mod_edge: assert property ($changed(panel_modulation_clock) |-> s_hs_lead or s_pol_ago)
    else $error("modulation moved off hsync plus four");
  a_pol_low: assert property (s_wr(PMP_POL_OFS) ##0 pstrb[0] |-> ##2
    panel_data_pin[7:2] == ($past(pwdata[7:2], 2) ^ $past(panel_data_in[7:2]))) else $error("low pins wrong");
  a_pol_high: assert property (s_wr(PMP_POL_OFS) ##0 pstrb[1] |-> ##2
    panel_data_pin[15:10] == ($past(pwdata[15:10], 2) ^ $past(panel_data_in[15:10]))) else $error("high pins wrong");
  a_rsvd_pass: assert property (panel_data_pin[1:0] == $past(panel_data_in[1:0])
    && panel_data_pin[9:8] == $past(panel_data_in[9:8])
    && panel_data_pin[17:16] == $past(panel_data_in[17:16])) else $error("reserved pins not straight");
  a_mod_pol: assert property (s_wr(PMP_POL_OFS) ##0 pstrb[3] |-> ##2
    (panel_modulation_clock ^ $past(panel_modulation_clock))
    == ($past(pwdata[PMP_POL_MOD_BIT], 2) ^ $past(pol_mod_r, 2))) else $error("modulation polarity wrong");
  a_slverr_map: assert property (psel && penable && paddr == 12'h700 |-> pslverr)
    else $error("unmapped access not flagged");
endmodule // pmp_props
bind pmp_panel_modulation_polarity pmp_props #(.PIN_W(PIN_W)) i_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pslverr(pslverr), .int_hsync(int_hsync), .panel_data_in(panel_data_in), .panel_data_pin(panel_data_pin),
  .frame_rate_gray_dither_tune(frame_rate_gray_dither_tune), .panel_modulation_clock(panel_modulation_clock));
`default_nettype wire

// File: pmp_panel_model.sv
// Purpose: Flat panel stand-in watching the modulation pin
// Assumes: Pins sampled on the pclk rising edge
// Notes: Counts pin changes only; pixel data is not kept
`timescale 1ns/1ps
`default_nettype none
module pmp_panel_model
  import pmp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic panel_modulation_clock,
  output logic [7:0] mod_edges
);
  logic mod_q_r;
  // Each level change of the pin is one modulation edge for the panel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mod_q_r <= 1'b0;
      mod_edges <= 8'h00;
    end
    else
    begin
      mod_q_r <= panel_modulation_clock;
      mod_edges <= mod_edges + 8'(mod_q_r ^ panel_modulation_clock);
    end
  end
endmodule // pmp_panel_model
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the panel modulation and polarity block
// Assumes: Zero-wait APB slave, 200 MHz pclk
// Notes: Hsync kept quiet around polarity writes
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench import pmp_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic int_vsync = 1'b0;
  logic int_hsync = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [17:0] panel_data_in = 18'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic panel_modulation_clock;
  logic m;
  logic [17:0] panel_data_pin;
  logic [7:0] mod_edges;
  pmp_tune_s tune;
  int fail_count = 0;
  int check_count = 0;
  // 5 ns period
  always #2.5 pclk = ~pclk;
  pmp_panel_modulation_polarity #(.PIN_W(18)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .int_vsync(int_vsync), .int_hsync(int_hsync),
    .panel_data_in(panel_data_in), .frame_rate_gray_dither_tune(tune), .panel_data_pin(panel_data_pin),
    .panel_modulation_clock(panel_modulation_clock));
  pmp_panel_model i_panel (.pclk(pclk), .presetn(presetn), .panel_modulation_clock(panel_modulation_clock),
    .mod_edges(mod_edges));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One APB transfer; a read compares against e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [31:0] e);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      fail_count++;
      give_verdict();
    end
    if (!w)
      `CHK("rdata", e, prdata)
    `CHK("slverr", a == 12'h700, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Hsync lead edge, pin must hold three cycles and then flip if tog
  task automatic hs(input logic tog);
    m = panel_modulation_clock;
    int_hsync <= 1'b1;
    @(posedge pclk);
    int_hsync <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    `CHK("mod early", m, panel_modulation_clock)
    @(posedge pclk);
    #1;
    `CHK("mod", m ^ tog, panel_modulation_clock)
    repeat (3) @(posedge pclk);
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb('0, PMP_MODCTL_OFS, '0, 4'h0, '0);
    apb('0, PMP_POL_OFS, '0, 4'h0, '0);
    apb('1, PMP_MODCTL_OFS, 32'h80a5_3cc3, 4'hf, '0);
    apb('1, PMP_MODCTL_OFS, 32'hffff_ff11, 4'h1, '0);
    apb('0, PMP_MODCTL_OFS, '0, 4'h0, 32'h80a5_3c11);
    `CHK("tune", 24'ha5_3c11, tune)
    hs(1'b1);
    hs(1'b1);
    // Half-period of f+1 hsync events
    for (int f = 1; f < 3; f++)
    begin
      apb('1, PMP_MODCTL_OFS, {1'b1, 7'(f), 24'h0}, 4'hf, '0);
      repeat (f) hs(1'b0);
      hs(1'b1);
    end
    apb('1, PMP_CFG_OFS, 32'h0040_0000, 4'hf, '0);
    hs(1'b1);
    apb('1, PMP_CFG_OFS, '0, 4'hf, '0);
    apb('1, PMP_MODCTL_OFS, '0, 4'hf, '0);
    hs(1'b0);
    int_vsync <= 1'b1;
    @(posedge pclk);
    int_vsync <= 1'b0;
    hs(1'b1);
    panel_data_in <= 18'h3_ffff;
    m = panel_modulation_clock;
    apb('1, PMP_POL_OFS, 32'h1000_fcfc, 4'hf, '0);
    @(posedge pclk);
    #1;
    `CHK("pins", 18'h3_0303, panel_data_pin)
    `CHK("mod pin", ~m, panel_modulation_clock)
    `CHK("edges", 8'h07, mod_edges)
    @(posedge pclk);
    apb('0, 12'h700, '0, 4'h0, '0);
    apb('0, PMP_POL_OFS, '0, 4'h0, 32'h1000_fcfc);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
